//--- hdl/nvm_seq_params.svh
/*
 Register offsets, field positions, unlock keys, address windows and timing
 constants of the write/erase sequencer. Definitions only.
*/
`ifndef NVM_SEQ_PARAMS_SVH
`define NVM_SEQ_PARAMS_SVH

// APB byte offsets
`define OFS_CONTROL 12'h000
`define OFS_KEY 12'h004
`define OFS_ADDR_LOW 12'h008
`define OFS_ADDR_HIGH 12'h00c
`define OFS_DATA_LOW 12'h010
`define OFS_DATA_HIGH 12'h014
`define OFS_STATUS 12'h018
`define OFS_PROTECT 12'h01c

// Control register fields
`define CTL_READ 0
`define CTL_WRITE 1
`define CTL_WRITE_ENABLE_BIT 2
`define CTL_ERR 3
`define CTL_FREE 4
`define CTL_LWLO 5
`define CTL_SPACE 6
`define CTL_WIDTH 7

// Status register fields
`define STS_DONE 0
`define STS_DONE_IE 1
`define STS_BUSY 2
`define STS_STALL 3

// Unlock keys
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'haa

// Address windows
`define PFM_LAST 15'h3fff
`define UID_LAST 15'h0003
`define UID_RESERVED 15'h0004
`define CFG_LAST 15'h000a
`define EE_BASE 15'h7000
`define EE_LAST 15'h70ff

// Identification-space word addresses
`define REV_ADDR 15'h0005
`define DEV_ADDR 15'h0006

// Timing in microseconds and derived cycles at 250 MHz
`define CLK_MHZ 250
`define EE_WRITE_US 4000
`define ROW_ERASE_US 2000
`define EE_WRITE_CYC (`EE_WRITE_US * `CLK_MHZ)
`define ROW_ERASE_CYC (`ROW_ERASE_US * `CLK_MHZ)

`define ERASED_WORD 14'h3fff

`endif

//--- hdl/nvm_seq_pkg.sv
/*
 Types shared by the sequencer and its array model.
 Assumes nvm_seq_params.svh defines the numeric constants.
*/
package nvm_seq_pkg;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_EE_WRITE = 3'b001,
      ST_ERASE = 3'b011,
      ST_FINISH = 3'b010
   } seq_state_t;

   typedef enum logic [1:0] {
      OP_READ = 2'b00,
      OP_EE_WRITE = 2'b01,
      OP_ROW_ERASE = 2'b10
   } array_op_t;

   typedef struct packed {
      logic valid;
      array_op_t op;
      logic space;
      logic [14:0] addr;
      logic [7:0] data;
   } array_req_t;

   typedef struct packed {
      logic [13:0] rdata;
   } array_rsp_t;

endpackage : nvm_seq_pkg

//--- hdl/nvm_array.sv
/*
 Storage behind the sequencer: program flash, user IDs, read-only
 identification words (revision and device) and the byte EEPROM.
 Assumes requests arrive one at a time from the sequencer, already checked.
*/
`timescale 1ns/1ns
`include "nvm_seq_params.svh"

module nvm_array #(
   parameter int PFM_WORDS = 16384,
   parameter int EE_BYTES = 256,
   parameter int ROW_WORDS = 32,
   // Arbitrary identification values
   parameter logic [13:0] REV_WORD = 14'h0001,
   parameter logic [13:0] DEV_WORD = 14'h0002
) (
   // Clock
   input wire logic core_clk,
   // Request and answer
   input wire nvm_seq_pkg::array_req_t req,
   output nvm_seq_pkg::array_rsp_t rsp
);
   import nvm_seq_pkg::*;

   localparam int PW = $clog2(PFM_WORDS);
   localparam int RW = $clog2(ROW_WORDS);

   logic [13:0] pfm [PFM_WORDS];
   logic [7:0] eeMem [EE_BYTES];
   logic [13:0] uid [4];

   always_ff @(posedge core_clk) begin
      if (req.valid && req.op == OP_ROW_ERASE && !req.space) begin
         for (int i = 0; i < ROW_WORDS; i++) begin
            pfm[{req.addr[PW-1:RW], RW'(i)}] <= `ERASED_WORD;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (req.valid && req.op == OP_ROW_ERASE && req.space) begin
         for (int i = 0; i < 4; i++) begin
            uid[i] <= `ERASED_WORD;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (req.valid && req.op == OP_EE_WRITE) begin
         eeMem[req.addr[7:0]] <= req.data;
      end
   end

   // Reads are combinational so the data pair loads one edge after the
   // request pulse, keeping the read stall to a single cycle
   always_comb begin
      rsp.rdata = `ERASED_WORD;
      if (req.valid && req.op == OP_READ) begin
         if (!req.space) begin
            rsp.rdata = pfm[req.addr[PW-1:0]];
         end else if (req.addr <= `UID_LAST) begin
            rsp.rdata = uid[req.addr[1:0]];
         end else if (req.addr == `REV_ADDR) begin
            rsp.rdata = REV_WORD;
         end else if (req.addr == `DEV_ADDR) begin
            rsp.rdata = DEV_WORD;
         end else if (req.addr >= `EE_BASE && req.addr <= `EE_LAST) begin
            rsp.rdata = {6'h00, eeMem[req.addr[7:0]]};
         end
      end
   end

endmodule : nvm_array

//--- hdl/nvm_write_erase_sequencer.sv
/*
 Self-programming sequencer: APB register file, two-key unlock, background
 EEPROM byte write, stalling row erase, one-cycle stalling read.
 Assumes an APB master on core_clk and a processor that honours cpuStall.
*/
// Operation
// - Start needs 55h, AAh, start, consecutively
// - Key tracking begins at first key write
// - EEPROM addressed at offset plus 7000h
// - EEPROM write erases its byte implicitly
// - EEPROM write runs background, then flags done
// - Clearing start during EEPROM write ignored
// - Flash erased by rows; no auto erase
// - Space bit picks flash or user IDs
// - Protected erase address: clear start, skip
// - Row erase stalls CPU, then flags done
// - Erase keeps latches and write enable
// - Address map decodes per space select
// - Start stalls CPU until stalling operation ends
// - Code protection blocks all accesses
// - Read stalls, data next cycle, bit cleared
`timescale 1ns/1ns
`include "nvm_seq_params.svh"

module nvm_write_erase_sequencer #(
   parameter int EE_WRITE_CYCLES = `EE_WRITE_CYC,
   parameter int ROW_ERASE_CYCLES = `ROW_ERASE_CYC,
   parameter logic [14:0] PROTECT_DEFAULT = 15'h0000
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Processor side
   input wire logic codeProtect,
   output logic cpuStall,
   output logic doneIrq
);
   import nvm_seq_pkg::*;

   localparam int CW = 32;

   function automatic logic isProtected(input logic [14:0] a,
                                        input logic [14:0] lim);
      return a < lim;
   endfunction : isProtected

   function automatic logic isEeAddr(input logic [14:0] a);
      return a >= `EE_BASE && a <= `EE_LAST;
   endfunction : isEeAddr

   // Shared write-strobe decode for the register file
   function automatic logic regHit(input logic acc, input logic [11:0] a,
                                   input logic [11:0] ofs);
      return acc && a == ofs;
   endfunction : regHit

   seq_state_t state_reg;
   logic [`CTL_WIDTH-1:0] memory_control_reg;
   logic [7:0] target_addr_low;
   logic [6:0] target_addr_high;
   logic [7:0] memory_data_low;
   logic [5:0] memory_data_high;
   logic memory_done_flag;
   logic memory_done_irq_enable;
   logic [14:0] protect_reg;
   logic [1:0] keyStage_reg;
   logic [CW-1:0] count_reg;
   logic readPending_reg;
   array_req_t arrReq;
   array_rsp_t arrRsp;

   logic wrAcc;
   logic rdAcc;
   logic keyWrite;
   logic ctlWrite;
   logic startReq;
   logic startOk;
   logic readReq;
   logic [14:0] memory_data_pair;
   logic [14:0] targetAddr;
   logic spaceSel;
   logic eeTarget;
   logic writeOk;
   logic eraseOk;
   logic rowProtected;
   logic mapped;

   assign wrAcc = psel && penable && pwrite;
   assign rdAcc = psel && penable && !pwrite;
   assign keyWrite = regHit(wrAcc, paddr, `OFS_KEY);
   assign ctlWrite = regHit(wrAcc, paddr, `OFS_CONTROL);
   assign targetAddr = {target_addr_high, target_addr_low};
   assign memory_data_pair = {1'b0, memory_data_high, memory_data_low};
   assign spaceSel = memory_control_reg[`CTL_SPACE];
   assign eeTarget = spaceSel && isEeAddr(targetAddr);
   // Start is only meaningful as the write immediately after both keys
   assign startReq = ctlWrite && pwdata[`CTL_WRITE]
      && !memory_control_reg[`CTL_WRITE] && state_reg == ST_IDLE;
   assign startOk = startReq && keyStage_reg == 2'd2
      && pwdata[`CTL_WRITE_ENABLE_BIT] && !codeProtect;
   assign readReq = ctlWrite && pwdata[`CTL_READ] && !codeProtect
      && state_reg == ST_IDLE;
   // EEPROM writes ignore the erase bit; flash row programming is absent
   assign writeOk = startOk && eeTarget
      && !pwdata[`CTL_LWLO];
   assign eraseOk = startOk && !eeTarget
      && pwdata[`CTL_FREE];
   // Only user IDs are erasable in the upper space
   assign rowProtected = spaceSel ? (targetAddr > `UID_LAST)
      : (targetAddr > `PFM_LAST
         || isProtected(targetAddr, protect_reg));
   assign mapped = paddr[1:0] == 2'b00 && paddr <= `OFS_PROTECT;

   // Key tracker: any APB access other than the expected next step resets it
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         keyStage_reg <= 2'd0;
      end else if (keyWrite) begin
         if (pwdata[7:0] == `KEY_FIRST) begin
            keyStage_reg <= 2'd1;
         end else if (pwdata[7:0] == `KEY_SECOND
                      && keyStage_reg == 2'd1) begin
            keyStage_reg <= 2'd2;
         end else begin
            keyStage_reg <= 2'd0;
         end
      end else if (wrAcc || rdAcc) begin
         keyStage_reg <= 2'd0;
      end
   end

   // Counter loads N-1 and ends at zero: the busy phase is N cycles
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         count_reg <= '0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (writeOk) begin
                  state_reg <= ST_EE_WRITE;
                  count_reg <= CW'(EE_WRITE_CYCLES - 1);
               end else if (eraseOk && !rowProtected) begin
                  state_reg <= ST_ERASE;
                  count_reg <= CW'(ROW_ERASE_CYCLES - 1);
               end
            end
            ST_EE_WRITE, ST_ERASE: begin
               if (count_reg == '0) begin
                  state_reg <= ST_FINISH;
               end else begin
                  count_reg <= count_reg - 1'b1;
               end
            end
            ST_FINISH: state_reg <= ST_IDLE;
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // Control register; start and read bits are owned by hardware once set
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         memory_control_reg <= '0;
      end else begin
         if (ctlWrite) begin
            memory_control_reg[`CTL_WRITE_ENABLE_BIT] <= pwdata[`CTL_WRITE_ENABLE_BIT];
            memory_control_reg[`CTL_FREE] <= pwdata[`CTL_FREE];
            memory_control_reg[`CTL_LWLO] <= pwdata[`CTL_LWLO];
            memory_control_reg[`CTL_SPACE] <= pwdata[`CTL_SPACE];
            memory_control_reg[`CTL_ERR] <= pwdata[`CTL_ERR];
         end
         if (state_reg == ST_IDLE) begin
            // Rejected or protected starts leave the bit clear
            memory_control_reg[`CTL_WRITE] <= writeOk
               || (eraseOk && !rowProtected);
         end else if (state_reg == ST_FINISH) begin
            memory_control_reg[`CTL_WRITE] <= 1'b0;
         end
         // Software clears of the start bit during a write are ignored
         memory_control_reg[`CTL_READ] <= readReq;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         target_addr_low <= '0;
         target_addr_high <= '0;
      end else if (wrAcc && state_reg == ST_IDLE) begin
         if (paddr == `OFS_ADDR_LOW) begin
            target_addr_low <= pwdata[7:0];
         end
         if (paddr == `OFS_ADDR_HIGH) begin
            target_addr_high <= pwdata[6:0];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         memory_data_low <= '0;
         memory_data_high <= '0;
      end else if (readPending_reg) begin
         memory_data_low <= arrRsp.rdata[7:0];
         memory_data_high <= arrRsp.rdata[13:8];
      end else if (wrAcc && state_reg == ST_IDLE) begin
         if (paddr == `OFS_DATA_LOW) begin
            memory_data_low <= pwdata[7:0];
         end
         if (paddr == `OFS_DATA_HIGH) begin
            memory_data_high <= pwdata[5:0];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         readPending_reg <= 1'b0;
      end else begin
         readPending_reg <= readReq;
      end
   end

   // Done flag: completion wins over a simultaneous software clear
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         memory_done_flag <= 1'b0;
         memory_done_irq_enable <= 1'b0;
      end else begin
         if (regHit(wrAcc, paddr, `OFS_STATUS)) begin
            memory_done_irq_enable <= pwdata[`STS_DONE_IE];
            if (!pwdata[`STS_DONE]) begin
               memory_done_flag <= 1'b0;
            end
         end
         if (state_reg == ST_FINISH) begin
            memory_done_flag <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         protect_reg <= PROTECT_DEFAULT;
      end else if (regHit(wrAcc, paddr, `OFS_PROTECT)) begin
         protect_reg <= pwdata[14:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         doneIrq <= 1'b0;
      end else begin
         doneIrq <= memory_done_flag && memory_done_irq_enable;
      end
   end

   // Stall covers the erase and the read cycle; EEPROM writes run free
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cpuStall <= 1'b0;
      end else begin
         cpuStall <= (eraseOk && !rowProtected && state_reg == ST_IDLE)
            || (state_reg == ST_ERASE && count_reg != '0)
            || readReq;
      end
   end

   // Array request is a one-cycle pulse; its fields keep their last values
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         arrReq <= '0;
      end else begin
         arrReq.valid <= 1'b0;
         if (readReq) begin
            arrReq.valid <= 1'b1;
            arrReq.op <= OP_READ;
            arrReq.space <= pwdata[`CTL_SPACE];
            arrReq.addr <= targetAddr;
         end else if (state_reg == ST_EE_WRITE && count_reg == '0) begin
            arrReq.valid <= 1'b1;
            arrReq.op <= OP_EE_WRITE;
            arrReq.space <= 1'b1;
            arrReq.addr <= targetAddr;
            arrReq.data <= memory_data_pair[7:0];
         end else if (state_reg == ST_ERASE && count_reg == '0) begin
            arrReq.valid <= 1'b1;
            arrReq.op <= OP_ROW_ERASE;
            arrReq.space <= spaceSel;
            arrReq.addr <= targetAddr;
         end
      end
   end

   // The setup edge registers pready, so every access ends at its first edge
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         prdata <= '0;
         if (psel && !penable && !pwrite) begin
            case (paddr)
               `OFS_CONTROL: prdata <= 32'(memory_control_reg);
               `OFS_ADDR_LOW: prdata <= 32'(target_addr_low);
               `OFS_ADDR_HIGH: prdata <= 32'(target_addr_high);
               `OFS_DATA_LOW: prdata <= 32'(memory_data_low);
               `OFS_DATA_HIGH: prdata <= 32'(memory_data_high);
               `OFS_STATUS: prdata <= 32'({cpuStall,
                  state_reg != ST_IDLE, memory_done_irq_enable,
                  memory_done_flag});
               `OFS_PROTECT: prdata <= 32'(protect_reg);
               default: prdata <= '0;
            endcase
         end
      end
   end

   nvm_array u_array (
      .core_clk(core_clk),
      .req(arrReq),
      .rsp(arrRsp)
   );

endmodule : nvm_write_erase_sequencer

//--- sim/nvm_seq_properties.sv
/*
 Port-level properties of the write/erase sequencer.
 Assumes it is bound to the sequencer and sees only that module's ports.
*/
`timescale 1ns/1ns
`include "nvm_seq_params.svh"

module nvm_seq_properties #(
   parameter int EE_WRITE_CYCLES = 20,
   parameter int ROW_ERASE_CYCLES = 20
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   // Processor side
   input wire logic codeProtect,
   input wire logic cpuStall,
   input wire logic doneIrq
);
   int stallCnt;
   logic [2:0] wrHist;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   // A stall with no recent register write means the start was not ours
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         wrHist <= 3'h0;
      end else begin
         wrHist <= {wrHist[1:0], psel && penable && pready && pwrite};
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n || !cpuStall) begin
         stallCnt <= 0;
      end else begin
         stallCnt <= stallCnt + 1;
      end
   end

   sequence setupPhase;
      psel && !penable;
   endsequence

   sequence accessPhase;
      psel && penable;
   endsequence

   a_ready_first_access: assert property (setupPhase ##1 accessPhase |-> pready)
      else $error("pready missing in first access cycle");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   a_err_unmapped: assert property (psel && penable && pready |->
      pslverr == (paddr > `OFS_PROTECT || paddr[1:0] != 2'h0))
      else $error("pslverr does not match address decode");
   a_reset_quiet: assert property (disable iff (1'h0)
      !rst_n |=> !pready && !cpuStall && !doneIrq)
      else $error("outputs active after reset edge");
   a_stall_bounded: assert property (stallCnt <= ROW_ERASE_CYCLES + 4)
      else $error("processor stalled too long");
   a_stall_cause: assert property ($rose(cpuStall) |-> wrHist != 3'h0)
      else $error("stall without a register write");
   a_protect_no_stall: assert property ($rose(cpuStall) |->
      !$past(codeProtect) && !$past(codeProtect, 2))
      else $error("stall started under code protection");
   a_irq_after_stall: assert property ($rose(doneIrq) |-> !cpuStall)
      else $error("done interrupt while still stalled");
   a_done_clears: assert property (psel && penable && pready && pwrite &&
      paddr == `OFS_STATUS && !pwdata[`STS_DONE] |-> ##2 !doneIrq)
      else $error("done interrupt survives flag clear");
endmodule : nvm_seq_properties

bind nvm_write_erase_sequencer nvm_seq_properties #(
   .EE_WRITE_CYCLES(EE_WRITE_CYCLES),
   .ROW_ERASE_CYCLES(ROW_ERASE_CYCLES)
) u_nvm_seq_properties (
   .core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
   .pready, .pslverr, .codeProtect, .cpuStall, .doneIrq
);

//--- sim/test_nvm_write_erase_sequencer.sv
/*
 Self-checking bench for the write/erase sequencer.
 Assumes the sequencer holds its own arrays; long timings are cut to 20.
*/
`timescale 1ns/1ns
`include "nvm_seq_params.svh"

module test_nvm_write_erase_sequencer;
   import nvm_seq_pkg::*;
   localparam logic [7:0] RD = 8'h01;
   localparam logic [7:0] START = 8'h02;
   localparam logic [7:0] ENABLE = 8'h04;
   localparam logic [7:0] ERASE = 8'h10;
   localparam logic [7:0] SPACE = 8'h40;
   logic coreClk = 1'h0;
   logic rstN = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic codeProtect = 1'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic cpuStall;
   logic doneIrq;
   logic [31:0] rdat;
   logic err;
   int errorCnt = 0;
   int nTests = 0;

   always #2 coreClk = ~coreClk;

   nvm_write_erase_sequencer #(
      .EE_WRITE_CYCLES(20),
      .ROW_ERASE_CYCLES(20),
      .PROTECT_DEFAULT(15'h0000)
   ) u_nvm_write_erase_sequencer (
      .core_clk(coreClk), .rst_n(rstN), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .codeProtect(codeProtect),
      .cpuStall(cpuStall), .doneIrq(doneIrq)
   );

   task automatic printVerdict;
      if (errorCnt == 0 && nTests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : printVerdict

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      nTests++;
      if (seen !== exp) begin
         errorCnt++;
         $display("BAD %0t: got %h, want %h", $time, seen, exp);
      end
   endtask : check

   task automatic apb(input logic wr, input logic [11:0] a,
         input logic [31:0] d);
      int n;
      n = 0;
      @(posedge coreClk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge coreClk);
      penable <= 1'h1;
      // Outputs change by NBA, so right after the edge we see sampled values
      do begin
         @(posedge coreClk);
         n++;
      end while (pready !== 1'h1);
      // No wait states: the answer stands in the first access cycle
      check(32'(n), 32'h1);
      rdat = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb

   task automatic setAddr(input logic [14:0] a);
      apb(1'h1, `OFS_ADDR_LOW, {24'h0, a[7:0]});
      apb(1'h1, `OFS_ADDR_HIGH, {25'h0, a[14:8]});
   endtask : setAddr

   // Gap puts an unrelated access between the keys, which must break them
   task automatic keys(input logic [7:0] ctl, input logic [7:0] k1 = 8'h55,
         input logic [7:0] k2 = 8'haa, input logic gap = 1'h0);
      apb(1'h1, `OFS_CONTROL, {24'h0, ctl});
      apb(1'h1, `OFS_KEY, {24'h0, k1});
      if (gap) begin
         apb(1'h1, `OFS_ADDR_LOW, 32'h40);
      end
      apb(1'h1, `OFS_KEY, {24'h0, k2});
      apb(1'h1, `OFS_CONTROL, {24'h0, ctl | START});
   endtask : keys

   task automatic waitIdle;
      int n;
      n = 0;
      do begin
         apb(1'h0, `OFS_STATUS, 32'h0);
         n++;
      end while (rdat[`STS_BUSY] !== 1'h0 && n < 40);
   endtask : waitIdle

   task automatic readWord(input logic sp, input logic [14:0] a,
         output logic [13:0] w);
      setAddr(a);
      apb(1'h1, `OFS_CONTROL, {24'h0, (sp ? SPACE : 8'h0) | RD});
      apb(1'h0, `OFS_DATA_LOW, 32'h0);
      w[7:0] = rdat[7:0];
      apb(1'h0, `OFS_DATA_HIGH, 32'h0);
      w[13:8] = rdat[5:0];
   endtask : readWord

   task automatic testMap;
      apb(1'h0, `OFS_CONTROL, 32'h0);
      check(rdat, 32'h0);
      apb(1'h0, 12'h020, 32'h0);
      check({err, rdat[30:0]}, 32'h8000_0000);
      apb(1'h1, 12'h006, 32'h55);
      check(32'(err), 32'h1);
   endtask : testMap

   // Writing the same byte twice only reads back right if each write erases
   task automatic eeWrite(input logic [7:0] d);
      logic [13:0] w;
      setAddr(`EE_BASE + 15'h05);
      apb(1'h1, `OFS_DATA_LOW, {24'h0, d});
      apb(1'h1, `OFS_STATUS, 32'h2);
      keys(SPACE | ENABLE);
      apb(1'h1, `OFS_CONTROL, {24'h0, SPACE | ENABLE});
      apb(1'h0, `OFS_CONTROL, 32'h0);
      check(32'(rdat[7:0]), 32'(SPACE | ENABLE | START));
      check(32'(cpuStall), 32'h0);
      waitIdle();
      check(32'(rdat[3:0]), 32'h3);
      apb(1'h0, `OFS_CONTROL, 32'h0);
      check(32'(rdat[7:0]), 32'(SPACE | ENABLE));
      check(32'(doneIrq), 32'h1);
      apb(1'h1, `OFS_STATUS, 32'h0);
      readWord(1'h1, `EE_BASE + 15'h05, w);
      check(32'(w[7:0]), 32'(d));
      check(32'(doneIrq), 32'h0);
      apb(1'h0, `OFS_CONTROL, 32'h0);
      check(32'(rdat[`CTL_READ]), 32'h0);
   endtask : eeWrite

   task automatic erase(input logic sp, input logic [14:0] a);
      logic [13:0] w;
      setAddr(a);
      keys((sp ? SPACE : 8'h0) | ERASE | ENABLE);
      repeat (3) @(posedge coreClk);
      check(32'(cpuStall), 32'h1);
      waitIdle();
      check(32'(rdat[`STS_DONE]), 32'h1);
      check(32'(cpuStall), 32'h0);
      apb(1'h0, `OFS_CONTROL, 32'h0);
      check(32'(rdat[7:0] & ENABLE), 32'(ENABLE));
      readWord(sp, a + 15'h01, w);
      check(32'(w), 32'(`ERASED_WORD));
      apb(1'h1, `OFS_STATUS, 32'h0);
   endtask : erase

   task automatic reject(input int kind);
      apb(1'h1, `OFS_PROTECT, kind == 4 ? 32'h100 : 32'h0);
      codeProtect <= (kind == 5);
      setAddr(kind == 3 ? 15'h0004 : 15'h0040);
      keys(kind == 0 ? ERASE : ERASE | ENABLE | (kind == 3 ? SPACE : 8'h0),
         kind == 2 ? 8'haa : 8'h55, kind == 2 ? 8'h55 : 8'haa, kind == 1);
      repeat (3) @(posedge coreClk);
      check(32'(cpuStall), 32'h0);
      apb(1'h0, `OFS_CONTROL, 32'h0);
      check(32'(rdat[`CTL_WRITE]), 32'h0);
      apb(1'h0, `OFS_STATUS, 32'h0);
      check(32'(rdat[`STS_DONE]), 32'h0);
      codeProtect <= 1'h0;
   endtask : reject

   initial begin
      repeat (10) @(posedge coreClk);
      rstN <= 1'h1;
      testMap();
      eeWrite(8'ha5);
      eeWrite(8'h5a);
      erase(1'h0, 15'h0040);
      erase(1'h1, 15'h0002);
      for (int k = 0; k < 6; k++) begin
         reject(k);
      end
      printVerdict();
   end

   // Whole run needs under a thousand cycles; four times that means a hang
   initial begin
      repeat (4000) @(posedge coreClk);
      errorCnt++;
      printVerdict();
   end
endmodule : test_nvm_write_erase_sequencer
